// ### ovl_params.svh
// Purpose: constants for the output/input voltage limit register group
// Assumes: included by bare name; definitions only
// Notes: command codes double as register offsets
`ifndef OVL_PARAMS_SVH
`define OVL_PARAMS_SVH
`define OVL_OFS_FORMAT 8'h20
`define OVL_OFS_SETPOINT 8'h21
`define OVL_OFS_CEILING 8'h24
`define OVL_OFS_MARGIN_HI 8'h25
`define OVL_OFS_MARGIN_LO 8'h26
`define OVL_OFS_DIVIDER 8'h29
`define OVL_OFS_FLOOR 8'h2b
`define OVL_OFS_VIN_START 8'h35
`define OVL_OFS_VIN_STOP 8'h36
`define OVL_OFS_CLEAR_FLAGS 8'h03
`define OVL_FORMAT_RESET 8'h40
`define OVL_FORMAT_MODE_MSB 7
`define OVL_FORMAT_MODE_LSB 5
`define OVL_FORMAT_EXP_MSB 4
`define OVL_VOLT_MSB 11
`define OVL_DIV_MSB 9
`define OVL_VIN_MSB 5
`define OVL_CEILING_MAX 12'hbb8
`define OVL_FLOOR_MIN 12'h0fa
`define OVL_SETPOINT_RESET 12'h1f4
`define OVL_CEILING_RESET 12'hbb8
`define OVL_FLOOR_RESET 12'h0fa
`define OVL_MARGIN_HI_RESET 12'h226
`define OVL_MARGIN_LO_RESET 12'h1c2
`define OVL_DIVIDER_RESET 10'h3e8
`define OVL_VIN_START_RESET 6'h10
`define OVL_VIN_STOP_RESET 6'h0e
`endif

// ### ovl_pkg.sv
// Purpose: types for the voltage limit register group
// Assumes: ovl_params.svh supplies the numbers
// Notes: none
package ovl_pkg;
	typedef enum logic [1:0] {
		ovl_sel_nominal,
		ovl_sel_margin_hi,
		ovl_sel_margin_lo
	} ovl_target_sel_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} ovl_req_t;
	typedef struct packed {
		logic [11:0] target;
		logic over;
		logic under;
	} ovl_clamp_t;
endpackage

// ### ovl_clamp.sv
// Purpose: clamp a commanded output voltage between floor and ceiling
// Assumes: all values in 2 mV counts
// Notes: with floor programmed above ceiling, ceiling wins only for commands above it; lower commands get the floor
`timescale 1ns/100ps
`include "ovl_params.svh"
module ovl_clamp
	import ovl_pkg::*;
(
	input wire logic [11:0] command,
	input wire logic [11:0] ceiling,
	input wire logic [11:0] floor_lvl,
	output ovl_clamp_t result
);
	// ceiling checked first: a command above it gets the ceiling, whatever the floor
	always_comb begin
		result.over = 1'b0;
		result.under = 1'b0;
		result.target = command;
		if (command > ceiling) begin
			result.target = ceiling;
			result.over = 1'b1;
		end else if (command < floor_lvl) begin
			result.target = floor_lvl;
			result.under = 1'b1;
		end
	end
endmodule

// ### ovl_fb_ref.sv
// Purpose: feedback reference from target and divider ratio
// Assumes: target 2 mV/count, ratio 0.001/count
// Notes: product is kept raw, scale 0.002 mV per count
`timescale 1ns/100ps
module ovl_fb_ref #(
	parameter int VW = 12,
	parameter int DW = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [VW-1:0] target,
	input wire logic [DW-1:0] ratio,
	output logic [VW+DW-1:0] fb_ref
);
	// registered so the multiplier path is cut from the loop output
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fb_ref <= '0;
		end else begin
			fb_ref <= target * ratio;
		end
	end
endmodule

// ### ovl_regs.sv
// Purpose: output/input voltage limit registers of a power converter
// Assumes: one-cycle read/write strobes from the management bus decoder
// Notes: reads return data one cycle after the strobe
// Function
// - format upper three bits mode, low five exponent
// - format register reads 0x40 from reset
// - setpoint 12 bits, 2 mV, upper bits read-only
// - feedback reference equals clamped target times divider ratio
// - above ceiling: clamp, set flags, notify host
// - ceiling 12 bits, checked before floor, max 6 V
// - below floor: clamp, set flags, notify host
// - floor 12 bits, 2 mV, min 0.5 V
// - divider ratio 10 bits, 0.001 per count
// - start when input reaches start threshold
// - stop when input falls to stop threshold
// - margin levels 12 bits, 2 mV, upper read-only
// - flag clear resets setpoint limit warning
`timescale 1ns/100ps
`include "ovl_params.svh"
module ovl_regs
	import ovl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input ovl_req_t req,
	output logic [15:0] rdata,
	output logic rvalid,
	output logic addr_err,
	input wire logic [1:0] margin_sel,
	input wire logic [5:0] vin_level,
	input wire logic start_ok,
	output logic [11:0] vout_target,
	output logic [21:0] fb_ref,
	output logic converter_on,
	output logic output_voltage_status,
	output logic setpoint_limit_warning,
	output logic host_notify
);
	logic [7:0] output_voltage_format;
	logic [11:0] output_voltage_setpoint;
	logic [11:0] output_voltage_ceiling;
	logic [11:0] upper_margin_level;
	logic [11:0] lower_margin_level;
	logic [9:0] feedback_divider_ratio;
	logic [11:0] output_voltage_floor;
	logic [5:0] input_start_threshold;
	logic [5:0] input_stop_threshold;
	logic [11:0] command;
	logic [11:0] prev_command;
	logic [11:0] prev_ceiling;
	logic [11:0] prev_floor;
	logic [1:0] sel_q;
	logic retarget;
	logic clear_cmd;
	logic [11:0] wr_volt;
	ovl_target_sel_t sel;
	ovl_clamp_t clamp;
	logic [5:0] vin_s1;
	logic [5:0] vin_s2;
	logic [5:0] vin_s3;
	logic [5:0] vin_level_q;

	// margin selection decode
	always_comb begin
		case (margin_sel)
			2'h1: sel = ovl_sel_margin_hi;
			2'h2: sel = ovl_sel_margin_lo;
			default: sel = ovl_sel_nominal;
		endcase
	end

	// the commanded level before limits
	always_comb begin
		case (sel)
			ovl_sel_margin_hi: command = upper_margin_level;
			ovl_sel_margin_lo: command = lower_margin_level;
			default: command = output_voltage_setpoint;
		endcase
	end

	assign wr_volt = req.wdata[`OVL_VOLT_MSB:0];
	assign clear_cmd = req.wr && (req.addr == `OVL_OFS_CLEAR_FLAGS);

	// format register is fixed: direct mode, exponent zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			output_voltage_format <= `OVL_FORMAT_RESET;
		end else begin
			output_voltage_format <= `OVL_FORMAT_RESET;
		end
	end

	// voltage registers; ceiling and floor writes are held to their legal range
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			output_voltage_setpoint <= `OVL_SETPOINT_RESET;
			output_voltage_ceiling <= `OVL_CEILING_RESET;
			output_voltage_floor <= `OVL_FLOOR_RESET;
			upper_margin_level <= `OVL_MARGIN_HI_RESET;
			lower_margin_level <= `OVL_MARGIN_LO_RESET;
		end else if (req.wr) begin
			case (req.addr)
				`OVL_OFS_SETPOINT: output_voltage_setpoint <= wr_volt;
				`OVL_OFS_CEILING: begin
					if (wr_volt > `OVL_CEILING_MAX) begin
						output_voltage_ceiling <= `OVL_CEILING_MAX;
					end else begin
						output_voltage_ceiling <= wr_volt;
					end
				end
				`OVL_OFS_FLOOR: begin
					if (wr_volt < `OVL_FLOOR_MIN) begin
						output_voltage_floor <= `OVL_FLOOR_MIN;
					end else begin
						output_voltage_floor <= wr_volt;
					end
				end
				`OVL_OFS_MARGIN_HI: upper_margin_level <= wr_volt;
				`OVL_OFS_MARGIN_LO: lower_margin_level <= wr_volt;
				default: ;
			endcase
		end
	end

	// divider and input thresholds; upper bits never stored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			feedback_divider_ratio <= `OVL_DIVIDER_RESET;
			input_start_threshold <= `OVL_VIN_START_RESET;
			input_stop_threshold <= `OVL_VIN_STOP_RESET;
		end else if (req.wr) begin
			case (req.addr)
				`OVL_OFS_DIVIDER: feedback_divider_ratio <= req.wdata[`OVL_DIV_MSB:0];
				`OVL_OFS_VIN_START: input_start_threshold <= req.wdata[`OVL_VIN_MSB:0];
				`OVL_OFS_VIN_STOP: input_stop_threshold <= req.wdata[`OVL_VIN_MSB:0];
				default: ;
			endcase
		end
	end

	ovl_clamp u_clamp (
		.command(command),
		.ceiling(output_voltage_ceiling),
		.floor_lvl(output_voltage_floor),
		.result(clamp)
	);

	// a change of command, selection or limit marks a retarget for the warning flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_command <= '0;
			prev_ceiling <= '0;
			prev_floor <= '0;
			sel_q <= 2'h0;
		end else begin
			prev_command <= command;
			prev_ceiling <= output_voltage_ceiling;
			prev_floor <= output_voltage_floor;
			sel_q <= margin_sel;
		end
	end
	assign retarget = (command != prev_command) || (sel_q != margin_sel) ||
		(prev_ceiling != output_voltage_ceiling) || (prev_floor != output_voltage_floor);

	// clamped target registered every cycle, so it follows a limit change one cycle later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vout_target <= `OVL_SETPOINT_RESET;
		end else begin
			vout_target <= clamp.target;
		end
	end

	// warning flags: a new limit event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			setpoint_limit_warning <= 1'b0;
			output_voltage_status <= 1'b0;
		end else if (retarget && (clamp.over || clamp.under)) begin
			setpoint_limit_warning <= 1'b1;
			output_voltage_status <= 1'b1;
		end else if (clear_cmd) begin
			setpoint_limit_warning <= 1'b0;
			output_voltage_status <= 1'b0;
		end
	end

	// notify level follows the sticky summary, like an alert line
	assign host_notify = output_voltage_status;

	ovl_fb_ref #(
		.VW(12),
		.DW(10)
	) u_fb_ref (
		.clk(clk),
		.rst_n(rst_n),
		.target(vout_target),
		.ratio(feedback_divider_ratio),
		.fb_ref(fb_ref)
	);

	// input level arrives from the converter's sampler, another domain
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vin_s1 <= '0;
			vin_s2 <= '0;
			vin_s3 <= '0;
			vin_level_q <= '0;
		end else begin
			vin_s1 <= vin_level;
			vin_s2 <= vin_s1;
			vin_s3 <= vin_s2;
			if (vin_s2 == vin_s3) begin
				vin_level_q <= vin_s3;
			end
		end
	end

	// hysteresis: on at start threshold, off at stop threshold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			converter_on <= 1'b0;
		end else if (converter_on) begin
			if (vin_level_q <= input_stop_threshold) begin
				converter_on <= 1'b0;
			end
		end else if (start_ok && (vin_level_q >= input_start_threshold)) begin
			converter_on <= 1'b1;
		end
	end

	// read port; unmapped offsets read zero and raise addr_err
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
			rvalid <= 1'b0;
			addr_err <= 1'b0;
		end else begin
			rvalid <= req.rd;
			addr_err <= 1'b0;
			if (req.rd) begin
				case (req.addr)
					`OVL_OFS_FORMAT: rdata <= {8'h00, output_voltage_format};
					`OVL_OFS_SETPOINT: rdata <= {4'h0, output_voltage_setpoint};
					`OVL_OFS_CEILING: rdata <= {4'h0, output_voltage_ceiling};
					`OVL_OFS_MARGIN_HI: rdata <= {4'h0, upper_margin_level};
					`OVL_OFS_MARGIN_LO: rdata <= {4'h0, lower_margin_level};
					`OVL_OFS_DIVIDER: rdata <= {6'h00, feedback_divider_ratio};
					`OVL_OFS_FLOOR: rdata <= {4'h0, output_voltage_floor};
					`OVL_OFS_VIN_START: rdata <= {10'h000, input_start_threshold};
					`OVL_OFS_VIN_STOP: rdata <= {10'h000, input_stop_threshold};
					default: begin
						rdata <= 16'h0000;
						addr_err <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule

// ### ovl_regs_properties.sv
// Purpose: timing and limit checks on the voltage limit registers
// Assumes: sync active-low reset, one-cycle strobes
// Notes: bound from the testbench top
`timescale 1ns/100ps
module ovl_regs_properties
	import ovl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input ovl_req_t req,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	input wire logic [11:0] vout_target,
	input wire logic output_voltage_status,
	input wire logic setpoint_limit_warning,
	input wire logic host_notify
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	fmt_read_a: assert property (req.rd && req.addr == 8'h20 |=> rdata == 16'h0040)
		else $error("format read wrong");
	upper_zero_a: assert property (rvalid |-> rdata[15:12] == 4'h0)
		else $error("read-only bits set");
	div_bits_a: assert property (req.rd && req.addr == 8'h29 |=> rdata[15:10] == 6'h00)
		else $error("divider upper bits set");
	vin_bits_a: assert property (req.rd && req.addr inside {8'h35, 8'h36} |=> rdata[15:6] == 10'h000)
		else $error("threshold upper bits set");
	ceil_bound_a: assert property (vout_target <= 12'hbb8)
		else $error("target above ceiling");
	floor_bound_a: assert property (vout_target >= 12'h0fa)
		else $error("target below floor");
	notify_tie_a: assert property (host_notify == output_voltage_status)
		else $error("notify differs from summary");
	warn_pair_a: assert property (setpoint_limit_warning |-> output_voltage_status)
		else $error("warning without summary");
	// a clear with no write in the cycle before must drop the warning
	flag_clear_a: assert property (req.wr && req.addr == 8'h03 && !$past(req.wr) |=> !setpoint_limit_warning)
		else $error("warning survived clear");
	warn_sticky_a: assert property (setpoint_limit_warning && !(req.wr && req.addr == 8'h03)
		|=> setpoint_limit_warning) else $error("warning dropped by itself");
endmodule

// ### ovl_host.sv
// Purpose: management bus host driving register requests
// Assumes: one-cycle strobes, read answer one cycle later
// Notes: idle bus carries inverted junk so stale values never pass
`timescale 1ns/100ps
module ovl_host
	import ovl_pkg::*;
(
	input wire logic clk,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	input wire logic addr_err,
	output ovl_req_t req
);
	initial req = '0;
	// one write strobe, then the bus is released
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, v};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, ~v};
	endtask
	// read strobe; answer taken only while rvalid stands
	task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic e);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		req <= '{1'b0, 1'b0, ~a, 16'h5a5a};
		#1;
		v = rvalid ? rdata : 16'hxxxx;
		e = addr_err;
	endtask
endmodule

// ### ovl_regs_tb.sv
// Purpose: self-checking bench for the voltage limit registers
// Assumes: host model issues all bus traffic
// Notes: reset values are the designer's arbitrary defaults
`timescale 1ns/100ps
module ovl_regs_tb;
	import ovl_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, start_ok = 1'b0, e;
	logic [1:0] margin_sel = 2'h0;
	logic [5:0] vin_level = 6'h00;
	logic [15:0] rdata, d;
	logic rvalid, addr_err, converter_on, ovs, slw, notify;
	logic [11:0] vout_target;
	logic [21:0] fb_ref;
	ovl_req_t req;
	int bad_count = 0, n_tests = 0, cyc = 0;
	logic [7:0] ofs [8] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h29, 8'h2b, 8'h35, 8'h36};
	logic [15:0] rv [8] = '{16'h01f4, 16'h0bb8, 16'h0226, 16'h01c2, 16'h03e8, 16'h00fa, 16'h0010, 16'h000e};
	logic [15:0] msk [8] = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h0fff, 16'h03ff, 16'h0fff, 16'h003f, 16'h003f};
	ovl_regs u_ovl_regs (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
		.addr_err(addr_err), .margin_sel(margin_sel), .vin_level(vin_level), .start_ok(start_ok),
		.vout_target(vout_target), .fb_ref(fb_ref), .converter_on(converter_on),
		.output_voltage_status(ovs), .setpoint_limit_warning(slw), .host_notify(notify));
	ovl_host u_ovl_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr_err(addr_err), .req(req));
	// 125 MHz clock
	always #4 clk = ~clk;
	// a hang is cut short well beyond the two hundred or so cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic chk(input logic [21:0] seen, input logic [21:0] want);
		n_tests++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// reset values, masked fields, refused writes, unmapped read
	task automatic t_regs;
		u_ovl_host.rd(8'h20, d, e);
		chk(22'(d), 22'h000040);
		chk(22'(d[7:5]), 22'h000002);
		u_ovl_host.wr(8'h20, 16'h1234);
		u_ovl_host.rd(8'h20, d, e);
		chk(22'(d), 22'h000040);
		u_ovl_host.rd(8'h22, d, e);
		chk(22'({e, d}), 22'h010000);
		for (int i = 0; i < 8; i++) begin
			u_ovl_host.rd(ofs[i], d, e);
			chk(22'(d), 22'(rv[i]));
			u_ovl_host.wr(ofs[i], 16'hfa5a);
			u_ovl_host.rd(ofs[i], d, e);
			chk(22'(d), 22'(16'hfa5a & msk[i]));
			u_ovl_host.wr(ofs[i], rv[i]);
		end
	endtask
	// clamping, flag clear, feedback product, margin selection
	task automatic t_clamp;
		u_ovl_host.wr(8'h03, 16'h0000);
		u_ovl_host.wr(8'h21, 16'h0fff);
		wt(2);
		chk(22'({slw, ovs, notify, vout_target}), 22'h007bb8);
		u_ovl_host.wr(8'h03, 16'h0000);
		wt(1);
		chk(22'({slw, ovs}), 22'h000000);
		u_ovl_host.wr(8'h21, 16'h0010);
		wt(2);
		chk(22'({slw, ovs, vout_target}), 22'h0030fa);
		u_ovl_host.wr(8'h03, 16'h0000);
		u_ovl_host.wr(8'h21, 16'h0300);
		wt(3);
		chk(fb_ref, 22'h0bb800);
		@(posedge clk) margin_sel <= 2'h2;
		wt(3);
		chk(22'({slw, vout_target}), 22'h0001c2);
		@(posedge clk) margin_sel <= 2'h1;
		wt(3);
		chk(22'(vout_target), 22'h000226);
		u_ovl_host.wr(8'h25, 16'h0fff);
		wt(2);
		chk(22'({slw, vout_target}), 22'h001bb8);
		// code 3 decodes as nominal, so the setpoint comes back
		@(posedge clk) margin_sel <= 2'h3;
		wt(3);
		chk(22'(vout_target), 22'h000300);
		u_ovl_host.wr(8'h24, 16'h0fff);
		u_ovl_host.rd(8'h24, d, e);
		chk(22'(d), 22'h000bb8);
		u_ovl_host.wr(8'h2b, 16'h0010);
		u_ovl_host.rd(8'h2b, d, e);
		chk(22'(d), 22'h0000fa);
	endtask
	task automatic vin(input logic [5:0] v, input logic on);
		@(posedge clk) vin_level <= v;
		wt(8);
		chk(22'(converter_on), 22'(on));
	endtask
	// start and stop thresholds with the hysteresis band between them
	// input drops below start before start_ok rises, else the unit starts at once
	task automatic t_vin;
		vin(6'h14, 1'b0);
		vin(6'h0f, 1'b0);
		@(posedge clk) start_ok <= 1'b1;
		vin(6'h0f, 1'b0);
		vin(6'h10, 1'b1);
		vin(6'h0f, 1'b1);
		vin(6'h0e, 1'b0);
	endtask
	// mid-run reset: outputs and registers return to their reset values
	task automatic t_reset;
		@(posedge clk) margin_sel <= 2'h0;
		@(posedge clk) rst_n <= 1'b0;
		wt(2);
		chk(22'({slw, ovs, converter_on, vout_target}), 22'h0001f4);
		chk(fb_ref, 22'h000000);
		@(posedge clk) rst_n <= 1'b1;
		wt(3);
		chk(fb_ref, 22'h07a120);
		u_ovl_host.rd(8'h21, d, e);
		chk(22'(d), 22'h0001f4);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		wt(1);
		t_regs();
		t_clamp();
		t_vin();
		t_reset();
		give_verdict();
	end
endmodule
bind ovl_regs ovl_regs_properties u_ovl_regs_properties (.clk, .rst_n, .req, .rdata, .rvalid,
	.vout_target, .output_voltage_status, .setpoint_limit_warning, .host_notify);
